// ---- logic/etc_pkg.sv ----
// constants and types for the exposure trigger control block
package etc_pkg;
  // clock and time base
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned US_CYCLES = CLK_MHZ; // cycles per microsecond
  // row interval per sensor variant, in nanoseconds
  localparam int unsigned ROW_NS_A = 12910;
  localparam int unsigned ROW_NS_B = 15000;
  localparam int unsigned CLK_NS = 1000 / CLK_MHZ;
  // row interval in cycles: a fixed duration, rounded down
  localparam int unsigned ROW_CYC_A = ROW_NS_A / CLK_NS;
  localparam int unsigned ROW_CYC_B = ROW_NS_B / CLK_NS;
  // default row count of the sensor
  localparam int unsigned ROWS_DEF = 8742;
  // exposure time limits in microseconds
  localparam logic [25:0] EXP_MIN_US = 26'h0000001;
  localparam logic [25:0] EXP_MAX_US = 26'h3938700;
  // trigger source codes
  localparam logic [4:0] SRC_GRABBER = 5'h0E;
  localparam logic [4:0] SRC_TIMER = 5'h12;
  localparam logic [4:0] SRC_LINE = 5'h16;
  // timer trigger source code selecting the external line
  localparam logic [4:0] TSRC_LINE = 5'h16;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EXPOSURE = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;
  localparam logic [7:0] REG_PERIOD = 8'h0C;
  localparam logic [7:0] REG_ROWS = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_FRAMES = 8'h18;
  // control register field positions
  localparam int unsigned CTL_TRIG_ON = 0;
  localparam int unsigned CTL_POL_RISE = 1;
  localparam int unsigned CTL_WIDTH = 2;
  localparam int unsigned CTL_ACQ = 3;
  localparam int unsigned CTL_VARIANT = 4;
  localparam int unsigned CTL_SRC_LO = 8;
  localparam int unsigned CTL_TSRC_LO = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h00000002;
  localparam logic [25:0] EXP_RST = 26'h00003E8;
  localparam logic [25:0] PERIOD_RST = 26'h00F4240;
  // exposure phase states, gray coded along idle-wait-expose
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_EXPOSE = 2'b11
  } etc_phase_t;
endpackage

// ---- logic/etc_exposure_trigger_control.sv ----
// exposure trigger selection, timing and rolling-shutter row sequencer
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module etc_exposure_trigger_control (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic externalInputLine,
  input wire logic grabberLine,
  output logic waitingForTrigger,
  output logic exposing,
  output logic rowReset,
  output logic rowRead,
  output logic [13:0] rowIndex,
  output logic overlapped
);
  import etc_pkg::*;

  typedef struct packed {
    // software settings
    logic [31:0] ctrl;
    logic [25:0] expo;
    logic [25:0] delay;
    logic [25:0] period;
    logic [13:0] rows;
    // bus data phase
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
    // pin synchronisers and edge history
    logic [1:0] lineSync;
    logic lineDly;
    logic [1:0] grabSync;
    logic grabDly;
    // time base, phase and counters
    logic [4:0] usDiv;
    etc_phase_t phase;
    logic [25:0] expCnt;
    logic [25:0] sinceStart;
    logic [25:0] frmCnt;
    logic delayRun;
    logic [25:0] dlyCnt;
    // row sweeps and reported pulses
    logic rstRun;
    logic [13:0] rstRow;
    logic rdRun;
    logic [13:0] rdRow;
    logic [9:0] rowTick;
    logic [9:0] rdTick;
    logic [13:0] rowOut;
    logic rowResetP;
    logic rowReadP;
    logic ovl;
    logic [15:0] frames;
  } etc_state_t;

  etc_state_t q, d;

  // row interval in cycles for the selected sensor variant
  function automatic logic [9:0] rowCycles(input logic variant);
    rowCycles = variant ? 10'(ROW_CYC_B) : 10'(ROW_CYC_A);
  endfunction

  // clamp a written exposure value into the accepted range
  function automatic logic [25:0] clampExp(input logic [31:0] v);
    if (v < {6'h00, EXP_MIN_US}) begin
      clampExp = EXP_MIN_US;
    end else if (v > {6'h00, EXP_MAX_US}) begin
      clampExp = EXP_MAX_US;
    end else begin
      clampExp = v[25:0];
    end
  endfunction

  // decoded settings and per-cycle strobes
  logic trigOn, polRise, widthMode, acqOn, variant;
  logic [4:0] src, tsrc;
  logic lineEdgeAct, lineEdgeOpp, grabEdgeAct, grabEdgeOpp;
  logic lineRise, lineFall, grabRise, grabFall;
  logic usTick, extSrc, startReq, endReq, busy, readoutBusy;
  logic addrPhase;
  logic [25:0] readoutUs;

  always_comb begin
    d = q;
    trigOn = q.ctrl[CTL_TRIG_ON];
    polRise = q.ctrl[CTL_POL_RISE];
    widthMode = q.ctrl[CTL_WIDTH];
    acqOn = q.ctrl[CTL_ACQ];
    variant = q.ctrl[CTL_VARIANT];
    src = q.ctrl[CTL_SRC_LO +: 5];
    tsrc = q.ctrl[CTL_TSRC_LO +: 5];

    // bus: posted write, read data decoded in the address phase and registered for the data phase
    addrPhase = hsel && hready && htrans[1];
    // write lands at the end of its data phase
    if (q.wrPend) begin
      case (q.wrAddr)
        REG_CTRL: d.ctrl = hwdata;
        REG_EXPOSURE: d.expo = clampExp(hwdata);
        REG_DELAY: d.delay = hwdata[25:0];
        REG_PERIOD: d.period = (hwdata[25:0] == 26'h0) ? 26'h1 : hwdata[25:0];
        REG_ROWS: d.rows = (hwdata[13:0] == 14'h0) ? 14'h1 : hwdata[13:0];
        default: d.wrPend = 1'b0;
      endcase
    end
    d.wrPend = addrPhase && hwrite;
    d.wrAddr = haddr[7:0];
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        REG_CTRL: d.rdata = q.ctrl;
        REG_EXPOSURE: d.rdata = {6'h00, q.expo};
        REG_DELAY: d.rdata = {6'h00, q.delay};
        REG_PERIOD: d.rdata = {6'h00, q.period};
        REG_ROWS: d.rdata = {18'h0, q.rows};
        REG_STATUS: d.rdata = {27'h0, q.delayRun, q.rdRun, q.ovl,
          q.phase == PH_EXPOSE, q.phase == PH_WAIT};
        REG_FRAMES: d.rdata = {16'h0, q.frames};
        default: d.rdata = 32'h00000000;
      endcase
    end

    // two-stage synchronisers, edges only taken after the second stage
    d.lineSync = {q.lineSync[0], externalInputLine};
    d.lineDly = q.lineSync[1];
    d.grabSync = {q.grabSync[0], grabberLine};
    d.grabDly = q.grabSync[1];
    lineRise = q.lineSync[1] && !q.lineDly;
    lineFall = !q.lineSync[1] && q.lineDly;
    grabRise = q.grabSync[1] && !q.grabDly;
    grabFall = !q.grabSync[1] && q.grabDly;
    lineEdgeAct = polRise ? lineRise : lineFall;
    lineEdgeOpp = polRise ? lineFall : lineRise;
    grabEdgeAct = polRise ? grabRise : grabFall;
    grabEdgeOpp = polRise ? grabFall : grabRise;

    // microsecond tick for time counters
    usTick = (q.usDiv == 5'(US_CYCLES - 1));
    d.usDiv = usTick ? 5'h00 : q.usDiv + 5'h01;

    // readout of a whole frame in microseconds, for overlap decisions
    readoutUs = 26'((32'(q.rows) * 32'(rowCycles(variant))) / US_CYCLES);
    readoutBusy = q.rdRun || q.rstRun;

    // delayed trigger: external edge arms the microsecond delay
    if (!trigOn || src != SRC_TIMER || tsrc != TSRC_LINE) begin
      d.delayRun = 1'b0;
    end else if (!q.delayRun && lineEdgeAct) begin
      d.delayRun = 1'b1;
      // start one below zero: the first tick only closes a partial
      // microsecond, so the programmed delay is never cut short
      d.dlyCnt = 26'h3FFFFFF;
    end else if (q.delayRun && usTick) begin
      d.dlyCnt = q.dlyCnt + 26'h1;
    end

    // start source selection
    extSrc = trigOn && (src == SRC_LINE || src == SRC_GRABBER);
    startReq = 1'b0;
    endReq = 1'b0;
    if (!trigOn) begin
      startReq = acqOn && (q.frmCnt >= q.period);
    end else if (src == SRC_LINE) begin
      startReq = lineEdgeAct;
      endReq = lineEdgeOpp;
    end else if (src == SRC_GRABBER) begin
      startReq = grabEdgeAct;
      endReq = grabEdgeOpp;
    end else if (src == SRC_TIMER) begin
      // equality, since the count starts at all ones
      startReq = q.delayRun && (q.dlyCnt == q.delay);
    end
    // a release is used once, even if the phase machine is blocked
    if (src == SRC_TIMER && startReq) begin
      d.delayRun = 1'b0;
    end

    // busy: triggered runs finish the frame unless overlap condition holds
    busy = trigOn && readoutBusy && !(q.expo + readoutUs <= q.period);

    // free-run period counter
    if (q.frmCnt < q.period && usTick) begin
      d.frmCnt = q.frmCnt + 26'h1;
    end
    if (usTick && q.sinceStart != 26'h3FFFFFF) begin
      d.sinceStart = q.sinceStart + 26'h1;
    end

    // exposure phase machine
    d.rowResetP = 1'b0;
    d.rowReadP = 1'b0;
    case (q.phase)
      PH_IDLE: begin
        if (acqOn && !busy) begin
          d.phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (!acqOn) begin
          d.phase = PH_IDLE;
        end else if (startReq && !busy) begin
          d.phase = PH_EXPOSE;
          d.expCnt = 26'h0;
          d.frmCnt = 26'h0;
          d.sinceStart = 26'h0;
          d.ovl = (q.sinceStart <= q.expo + readoutUs);
          d.frames = q.frames + 16'h0001;
          d.rstRun = 1'b1;
          d.rstRow = 14'h0;
          d.rowTick = 10'h0;
          d.rowResetP = 1'b1;
          d.rowOut = 14'h0;
        end
      end
      PH_EXPOSE: begin
        // start edges while exposing are not acted on; in width mode with the line or grabber source the opposite edge ends exposure
        if (extSrc && widthMode) begin
          if (endReq) begin
            d.phase = acqOn ? PH_WAIT : PH_IDLE;
          end
        end else begin
          if (usTick) begin
            d.expCnt = q.expCnt + 26'h1;
          end
          // one extra tick: the first one ends a partial microsecond,
          // so exposure is never shorter than programmed, at most 1 us more
          if (usTick && q.expCnt >= q.expo) begin
            d.phase = acqOn ? PH_WAIT : PH_IDLE;
          end
        end
        if (d.phase != PH_EXPOSE) begin
          d.rdRun = 1'b1;
          d.rdRow = 14'h0;
          d.rdTick = 10'h0;
          d.rowReadP = 1'b1;
          d.rowOut = 14'h0;
        end
      end
      default: d.phase = PH_IDLE;
    endcase

    // row reset sweep, one row interval apart
    if (q.rstRun && !(q.phase == PH_WAIT && d.phase == PH_EXPOSE)) begin
      if (q.rowTick == rowCycles(variant) - 10'h1 && d.rowReadP) begin
        // row 0 read owns rowIndex this cycle; the reset slips one cycle
        d.rowTick = q.rowTick;
      end else if (q.rowTick == rowCycles(variant) - 10'h1) begin
        d.rowTick = 10'h0;
        if (q.rstRow + 14'h1 >= q.rows) begin
          d.rstRun = 1'b0;
        end else begin
          d.rstRow = q.rstRow + 14'h1;
          d.rowResetP = 1'b1;
          d.rowOut = q.rstRow + 14'h1;
        end
      end else begin
        d.rowTick = q.rowTick + 10'h1;
      end
    end

    // row readout sweep, each row one row interval, overlaps next exposure
    if (q.rdRun && !(q.phase == PH_EXPOSE && d.phase != PH_EXPOSE)) begin
      if (q.rdTick == rowCycles(variant) - 10'h1 && d.rowResetP) begin
        // a reset pulse owns rowIndex this cycle; the read slips one cycle
        d.rdTick = q.rdTick;
      end else if (q.rdTick == rowCycles(variant) - 10'h1) begin
        d.rdTick = 10'h0;
        if (q.rdRow + 14'h1 >= q.rows) begin
          d.rdRun = 1'b0;
        end else begin
          d.rdRow = q.rdRow + 14'h1;
          d.rowReadP = 1'b1;
          d.rowOut = q.rdRow + 14'h1;
        end
      end else begin
        d.rdTick = q.rdTick + 10'h1;
      end
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.expo <= EXP_RST;
      q.period <= PERIOD_RST;
      q.rows <= 14'(ROWS_DEF);
      q.lineSync <= 2'b00;
      q.phase <= PH_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // waiting only while a start would be taken, not behind a readout
  assign waitingForTrigger = (q.phase == PH_WAIT) && !busy;
  assign exposing = (q.phase == PH_EXPOSE);
  assign rowReset = q.rowResetP;
  assign rowRead = q.rowReadP;
  assign rowIndex = q.rowOut;
  assign overlapped = q.ovl;
endmodule // etc_exposure_trigger_control

// ---- testbench/etc_trigger_properties.sv ----
// assertion checker for the exposure trigger control block
`timescale 1ns/10ps
module etc_trigger_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic waitingForTrigger,
  input wire logic exposing,
  input wire logic rowReset,
  input wire logic rowRead,
  input wire logic [13:0] rowIndex
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // zero wait states and OKAY only
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not okay");
  // sync reset leaves the frame logic quiet
  property p_rst_quiet;
    $fell(rst) |-> !exposing && !waitingForTrigger && !rowReset;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
  property p_leave_wait;
    $rose(exposing) |-> $past(waitingForTrigger) && !waitingForTrigger;
  endproperty
  a_leave_wait: assert property (p_leave_wait)
    else $error("start not from waiting");
  property p_excl;
    !(waitingForTrigger && exposing);
  endproperty
  a_excl: assert property (p_excl) else $error("waiting while exposing");
  property p_start_row0;
    $rose(exposing) |-> rowReset && rowIndex == 14'h0000;
  endproperty
  a_start_row0: assert property (p_start_row0)
    else $error("first row not reset at start");
  property p_rst_gap;
    rowReset |=> !rowReset [*8];
  endproperty
  a_rst_gap: assert property (p_rst_gap) else $error("row resets too close");
  property p_rd_gap;
    rowRead |=> !rowRead [*8];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("row reads too close");
  property p_rd_first;
    $fell(exposing) |-> rowRead && rowIndex == 14'h0000;
  endproperty
  a_rd_first: assert property (p_rd_first)
    else $error("row zero not read at exposure end");
  property p_idx_hold;
    !rowReset && !rowRead |-> $stable(rowIndex);
  endproperty
  a_idx_hold: assert property (p_idx_hold)
    else $error("row index moved without pulse");
endmodule // etc_trigger_properties
bind etc_exposure_trigger_control etc_trigger_properties u_props (
  .mclk(mclk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .waitingForTrigger(waitingForTrigger), .exposing(exposing),
  .rowReset(rowReset), .rowRead(rowRead), .rowIndex(rowIndex));

// ---- testbench/etc_trig_source.sv ----
// far-side model: external trigger line and frame grabber line
`timescale 1ns/10ps
module etc_trig_source (
  input wire logic mclk,
  output logic extLine,
  output logic grabLine
);
  initial begin
    extLine = 1'b0;
    grabLine = 1'b0;
  end
  // both lines rest at the inactive level between frames
  task automatic park(input logic v);
    @(posedge mclk);
    extLine <= v;
    grabLine <= v;
  endtask
  // four edges, hold cycles apart; the later ones test discarding
  task automatic pulses(input logic grab, input logic lvl, input int hold);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      if (grab) grabLine <= lvl ^ i[0];
      else extLine <= lvl ^ i[0];
      repeat (hold - 1) @(posedge mclk);
    end
  endtask
endmodule // etc_trig_source

// ---- testbench/tb_exposure_trigger_control.sv ----
// self-checking bench for the exposure trigger control block
`timescale 1ns/10ps
module tb_exposure_trigger_control;
  import etc_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic grab;
    logic lvl;
    int hold, latLo, latHi, lenLo, lenHi, gap;
  } etc_row_t;
  logic mclk = 1'b0, rst = 1'b1, hwrite = 1'b0, hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, extLine, grabLine, waiting, exposing;
  logic rowReset, rowRead, overlapped;
  logic [13:0] rowIndex;
  int n_mismatch = 0, checked = 0, nExp = 0, nRst = 0, nRd = 0;
  int gapCnt = 0, lastGap = 0, e0;
  // ctrl, grab, level, hold, latency and length windows, row gap
  etc_row_t rows[6] = '{
    '{32'h0000160B, 0, 1, 60, 3, 6, 1998, 2022, ROW_CYC_A},
    '{32'h00001619, 0, 0, 60, 3, 6, 1998, 2022, ROW_CYC_B},
    '{32'h0000160F, 0, 1, 300, 3, 6, 296, 302, ROW_CYC_A},
    '{32'h00000E0B, 1, 1, 60, 3, 6, 1998, 2022, ROW_CYC_A},
    '{32'h00000E0D, 1, 0, 300, 3, 6, 296, 302, ROW_CYC_A},
    '{32'h0016120B, 0, 1, 60, 100, 130, 1998, 2022, ROW_CYC_A}};
  always #25 mclk = ~mclk;
  etc_exposure_trigger_control u_dut (.mclk(mclk), .rst(rst),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hsel(hsel), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .externalInputLine(extLine),
    .grabberLine(grabLine), .waitingForTrigger(waiting),
    .exposing(exposing), .rowReset(rowReset), .rowRead(rowRead),
    .rowIndex(rowIndex), .overlapped(overlapped));
  etc_trig_source u_src (.mclk(mclk), .extLine(extLine),
    .grabLine(grabLine));
  // event counts; tasks read them on the falling edge to avoid races
  always @(posedge mclk) begin
    gapCnt <= rowReset ? 1 : gapCnt + 1;
    if (rowReset) lastGap <= gapCnt;
    nExp <= nExp + int'(rowReset && rowIndex == 14'h0);
    nRst <= nRst + int'(rowReset);
    nRd <= nRd + int'(rowRead);
  end
  task automatic report_and_stop;
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tout;
    n_mismatch++;
    report_and_stop;
  endtask
  task automatic waitRdy;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) tout;
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q);
    @(posedge mclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    waitRdy;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy;
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // waits at most n falling edges for the flag to reach v
  task automatic waitFor(ref logic s, input logic v, input int n,
    output int c);
    c = 0;
    while (s !== v && c < n) begin
      @(negedge mclk);
      c++;
    end
    if (c >= n) tout;
  endtask
  task automatic runRow(input etc_row_t r);
    int r0, d0, lat, len, c;
    bus(1, REG_CTRL, r.ctrl & ~32'h8, rd);
    u_src.park(~r.lvl);
    bus(1, REG_CTRL, r.ctrl, rd);
    waitFor(waiting, 1'b1, 200, c);
    e0 = nExp;
    r0 = nRst;
    d0 = nRd;
    fork
      u_src.pulses(r.grab, r.lvl, r.hold);
    join_none
    waitFor(exposing, 1'b1, 500, lat);
    waitFor(exposing, 1'b0, 30000, len);
    waitFor(waiting, 1'b1, 20000, c);
    repeat (r.gap + 5) @(negedge mclk);
    chk(32'(lat >= r.latLo && lat <= r.latHi), 32'h1);
    chk(32'(len >= r.lenLo && len <= r.lenHi), 32'h1);
    chk(32'(nExp - e0), 32'h1);
    chk(32'(nRst - r0), 32'h3);
    chk(32'(nRd - d0), 32'h3);
    chk(32'(lastGap), 32'(r.gap));
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped read, exposure clamping
    bus(0, REG_CTRL, 32'h0, rd);
    chk(rd, CTRL_RST);
    bus(0, REG_EXPOSURE, 32'h0, rd);
    chk(rd, {6'h0, EXP_RST});
    bus(0, 8'h1C, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1, REG_EXPOSURE, 32'h0, rd);
    bus(0, REG_EXPOSURE, 32'h0, rd);
    chk(rd, {6'h0, EXP_MIN_US});
    bus(1, REG_EXPOSURE, 32'hFFFFFFFF, rd);
    bus(0, REG_EXPOSURE, 32'h0, rd);
    chk(rd, {6'h0, EXP_MAX_US});
    // short frames keep the run brief; period 1 blocks overlap
    bus(1, REG_EXPOSURE, 32'h64, rd);
    bus(1, REG_ROWS, 32'h3, rd);
    bus(1, REG_PERIOD, 32'h1, rd);
    bus(1, REG_DELAY, 32'h5, rd);
    foreach (rows[i]) runRow(rows[i]);
    // free run with a period shorter than exposure plus readout
    bus(1, REG_PERIOD, 32'h78, rd);
    bus(1, REG_CTRL, 32'h0000000A, rd);
    e0 = nExp;
    repeat (7000) @(negedge mclk);
    chk(32'(nExp - e0 >= 2), 32'h1);
    chk({31'h0, overlapped}, 32'h1);
    bus(1, REG_CTRL, 32'h00000002, rd);
    repeat (100) @(negedge mclk);
    e0 = nExp;
    repeat (7000) @(negedge mclk);
    chk(32'(nExp - e0), 32'h0);
    // reset again in mid-run
    bus(1, REG_CTRL, 32'h0000000A, rd);
    repeat (50) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({30'h0, exposing, waiting}, 32'h0);
    bus(0, REG_CTRL, 32'h0, rd);
    chk(rd, CTRL_RST);
    report_and_stop;
  end
endmodule // tb_exposure_trigger_control
